// ---- common/ssl_consts.svh ----
// Purpose: Constants of the stacked serial packet link
// Assumes: Included by bare name
// Notes: Counts are bytes of a packet, counted from zero
`ifndef SSL_CONSTS_SVH
`define SSL_CONSTS_SVH
// ==========================================
// Addressing
`define SSL_ADDR_ZERO 6'h00
`define SSL_ADDR_MAX 6'h3e
`define SSL_ADDR_BCAST 6'h3f
// ==========================================
// Checksum
`define SSL_CRC_POLY 8'h07
`define SSL_CRC_INIT 8'h00
// ==========================================
// Byte positions and lengths
`define SSL_BYTE_ADDR 9'h000
`define SSL_BYTE_REG 9'h001
`define SSL_BYTE_LEN 9'h002
`define SSL_WR_LEN 9'h003
`define SSL_WR_LEN_CRC 9'h004
`define SSL_BIT_LAST 3'h7
// ==========================================
// Buffering
`define SSL_FIFO_DEPTH 8
`endif

// ---- common/ssl_fifo_if.sv ----
// Purpose: Push and pop sides of the write queue
// Assumes: Single clock
// Notes: Valid and ready on both sides
`timescale 1ns/1ps
interface ssl_fifo_if #(parameter int W = 17);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   modport fifo (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface : ssl_fifo_if

// ---- common/ssl_pkg.sv ----
// Purpose: Types shared by the packet link modules
// Assumes: Nothing
// Notes: Constants live in ssl_consts.svh
package ssl_pkg;
   // ==========================================
   // Packet phase
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HEAD = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ = 3'b011,
      ST_RCRC = 3'b100,
      ST_SKIP = 3'b101
   } ssl_state_t;
   // ==========================================
   // Accepted register write
   typedef struct packed {
      logic bcast;
      logic [7:0] offset;
      logic [7:0] data;
   } ssl_wr_t;
endpackage : ssl_pkg

// ---- logic/ssl_fifo.sv ----
// Purpose: Queue of accepted register writes
// Assumes: DEPTH is a power of two
// Notes: Pop data is read from the register array
`timescale 1ns/1ps
module ssl_fifo
   import ssl_pkg::*;
#(
   parameter int W = 17,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Queue sides
   ssl_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = f.push_valid & f.push_ready;
   wire pop = f.pop_valid & f.pop_ready;

   // ==========================================
   // Flags
   assign f.push_ready = count != FULL;
   assign f.pop_valid = count != '0;
   assign f.pop_data = mem[rd_ptr];

   // ==========================================
   // Storage
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= f.push_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ssl_fifo

// ---- logic/ssl_link.sv ----
// Purpose: Packet layer of a stackable serial monitor link
// Assumes: Serial clock far slower than CLK; register file outside
// Notes: Serial, select, alert and base-select pins pass a two-stage synchroniser first
// Operation
// - Vertical chip select is active high
// - Vertical lines idle low while deselected
// - Clock and data forwarded without inversion
// - Return data outputs low unless returning data
// - Read data shifted south, base drives host
// - Supplier appends checksum after read data
// - Write data relayed north up the stack
// - Bad checksum raises alert relayed south
// - Address 0x3f write is broadcast to valid
// - Broadcast write starts conversions together
// - Writes carry one byte, address shifted, W
// - Order address, offset, count or data, checksum
// - Checksum only while checking is enabled
// - CRC-8 poly 07, MSB first, all bytes but filler and returned checksum
// - Read checksum excludes host filler bytes
// - Checksum checked at select release
// - Mismatch discards packet, latches fault flag
// - Fault flag holds until FAULT_CLEAR
// - Mode 1, sample falling, MSB first
// - Valid addresses 0x01 to 0x3e
// - Address zero blocks north chip select
`timescale 1ns/1ps
`include "ssl_consts.svh"
module ssl_link
   import ssl_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Host side
   input wire logic HOST_CS_B,
   input wire logic HOST_SCLK,
   input wire logic HOST_SERIAL_IN,
   output logic HOST_SERIAL_OUT,
   output logic HOST_SERIAL_OUT_EN,
   output logic HOST_ALERT,
   // South side
   input wire logic SOUTH_CS,
   input wire logic SOUTH_SCLK,
   input wire logic SOUTH_SERIAL_IN,
   output logic SOUTH_SERIAL_OUT,
   output logic SOUTH_ALERT,
   // North side
   input wire logic NORTH_SERIAL_IN,
   input wire logic NORTH_ALERT,
   output logic NORTH_CS,
   output logic NORTH_SCLK,
   output logic NORTH_SERIAL_OUT,
   // Configuration and status
   input wire logic BASE_SEL,
   input wire logic [5:0] DEV_ADDR,
   input wire logic CHECKSUM_DISABLE,
   input wire logic FAULT_CLEAR,
   output logic VERTICAL_STACK_BUS_IDLE,
   output logic CRC_FAULT,
   // Register file
   input wire logic [7:0] RD_DATA,
   output logic [7:0] RD_ADDR,
   input wire logic WR_READY,
   output logic WR_VALID,
   output logic WR_BCAST,
   output logic [7:0] WR_OFFSET,
   output logic [7:0] WR_DATA
);
   // ==========================================
   // Synchroniser
   logic [8:0] meta;
   logic [8:0] sync;
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         meta <= 9'h000;
         sync <= 9'h000;
      end
      else
      begin
         meta <= {BASE_SEL, HOST_CS_B, HOST_SCLK, HOST_SERIAL_IN, SOUTH_CS,
                  SOUTH_SCLK, SOUTH_SERIAL_IN, NORTH_SERIAL_IN, NORTH_ALERT};
         sync <= meta;
      end
   end
   wire base = sync[8];
   wire n_sdi = sync[1];
   wire n_alert = sync[0];
   wire cs_act = base ? !sync[7] : sync[4];
   wire sck = base ? sync[6] : sync[3];
   wire sdi = base ? sync[5] : sync[2];
   wire crc_en = !CHECKSUM_DISABLE;
   wire addr_valid = (DEV_ADDR != `SSL_ADDR_ZERO) && (DEV_ADDR <= `SSL_ADDR_MAX);

   // ==========================================
   // Edges
   logic sck_q;
   logic cs_q;
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sck_q <= 1'b0;
         cs_q <= 1'b0;
      end
      else
      begin
         sck_q <= sck;
         cs_q <= cs_act;
      end
   end
   // shift on rise, sample on fall
   wire rise = cs_act & sck & !sck_q;
   wire fall = cs_act & !sck & sck_q;
   wire cs_end = cs_q & !cs_act;

   // ==========================================
   // Shifting
   ssl_state_t st;
   ssl_state_t next_st;
   logic [2:0] bit_cnt;
   logic [8:0] byte_cnt;
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   logic [7:0] crc;
   logic rw;
   logic bcast;
   logic [7:0] offset;
   logic [7:0] len;
   logic [7:0] wdata;
   wire byte_done = fall && bit_cnt == `SSL_BIT_LAST;
   wire [7:0] rx_byte = {sh_in[6:0], sdi};
   wire is_bc = rx_byte[6:1] == `SSL_ADDR_BCAST;
   wire hit_now = !rx_byte[7]
                  && (rx_byte[6:1] == DEV_ADDR || (is_bc && rx_byte[0] && addr_valid));
   wire tx_on = st == ST_READ || st == ST_RCRC;
   wire last_data = byte_cnt == ({1'b0, len} + `SSL_BYTE_LEN);
   // filler and returned checksum bytes not fed
   wire feed = st == ST_HEAD || st == ST_WRITE || st == ST_READ;
   wire [7:0] tx_load = (st == ST_READ) ? RD_DATA : (st == ST_RCRC) ? crc : 8'h00;
   wire crc_bit_in = (st == ST_READ) ? sh_out[7] : sdi;

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SSL_CRC_POLY : 8'h00);
   endfunction : crc_step

   always_comb
   begin
      next_st = st;
      if (!cs_act)
         next_st = ST_IDLE;
      else if (st == ST_IDLE)
         next_st = ST_HEAD;
      else if (byte_done)
      begin
         unique case (st)
            ST_HEAD:
            begin
               if (byte_cnt == `SSL_BYTE_ADDR && !hit_now)
                  next_st = ST_SKIP;
               else if (byte_cnt == `SSL_BYTE_REG && rw)
                  next_st = ST_WRITE;
               else if (byte_cnt == `SSL_BYTE_LEN)
                  next_st = (rx_byte != 8'h00) ? ST_READ : crc_en ? ST_RCRC : ST_SKIP;
            end
            ST_READ: next_st = !last_data ? ST_READ : crc_en ? ST_RCRC : ST_SKIP;
            ST_RCRC: next_st = ST_SKIP;
            ST_IDLE, ST_WRITE, ST_SKIP: next_st = st;
            default: next_st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         st <= ST_IDLE;
      else
         st <= next_st;
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         bit_cnt <= 3'h0;
         byte_cnt <= 9'h000;
         sh_in <= 8'h00;
         crc <= `SSL_CRC_INIT;
      end
      else if (st == ST_IDLE)
      begin
         bit_cnt <= 3'h0;
         byte_cnt <= 9'h000;
         crc <= `SSL_CRC_INIT;
      end
      else if (fall)
      begin
         bit_cnt <= bit_cnt + 3'h1;
         byte_cnt <= byte_cnt + 9'(byte_done);
         sh_in <= rx_byte;
         crc <= feed ? crc_step(crc, crc_bit_in) : crc;
      end
   end

   // address byte, W in bit zero
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rw <= 1'b0;
         bcast <= 1'b0;
         offset <= 8'h00;
         len <= 8'h00;
         wdata <= 8'h00;
      end
      else if (byte_done)
      begin
         rw <= (byte_cnt == `SSL_BYTE_ADDR) ? rx_byte[0] : rw;
         bcast <= (byte_cnt == `SSL_BYTE_ADDR) ? is_bc : bcast;
         offset <= (byte_cnt == `SSL_BYTE_REG) ? rx_byte : offset;
         len <= (byte_cnt == `SSL_BYTE_LEN && !rw) ? rx_byte : len;
         wdata <= (byte_cnt == `SSL_BYTE_LEN && rw) ? rx_byte : wdata;
      end
   end

   // read data out on rising edges
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         sh_out <= 8'h00;
         RD_ADDR <= 8'h00;
      end
      else if (byte_done && byte_cnt == `SSL_BYTE_REG)
         RD_ADDR <= rx_byte;
      else if (rise)
      begin
         sh_out <= (bit_cnt == 3'h0) ? tx_load : {sh_out[6:0], 1'b0};
         RD_ADDR <= RD_ADDR + 8'((bit_cnt == 3'h0) && st == ST_READ);
      end
   end

   // ==========================================
   // Write acceptance
   // checked when select drops
   wire wr_end = cs_end && st == ST_WRITE;
   wire wr_ok = bit_cnt == 3'h0 && (crc_en ? (byte_cnt == `SSL_WR_LEN_CRC
                && crc == `SSL_CRC_INIT) : byte_cnt == `SSL_WR_LEN);
   wire bad = wr_end && !wr_ok && crc_en;
   logic fault;
   logic pend;
   ssl_wr_t pend_word;
   ssl_fifo_if #(.W($bits(ssl_wr_t))) fq ();
   assign fq.push_valid = pend;
   assign fq.push_data = pend_word;

   // flag sets only at packet end, clears on FAULT_CLEAR
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         fault <= 1'b0;
      else
         fault <= bad || (fault && !FAULT_CLEAR);
   end

   // broadcast flag goes to registers
   // A write ending while a held write waits on a full queue is dropped
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pend <= 1'b0;
         pend_word <= '0;
      end
      else if (wr_end && wr_ok && !(pend && !fq.push_ready))
      begin
         pend <= 1'b1;
         pend_word <= '{bcast: bcast, offset: offset, data: wdata};
      end
      else if (fq.push_ready)
         pend <= 1'b0;
   end

   ssl_fifo #(.W($bits(ssl_wr_t)), .DEPTH(`SSL_FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst_b(RST_B),
      .f(fq)
   );

   // Output stage keeps write outputs on flops
   assign fq.pop_ready = !WR_VALID || WR_READY;
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         WR_VALID <= 1'b0;
         {WR_BCAST, WR_OFFSET, WR_DATA} <= '0;
      end
      else if (fq.pop_ready)
      begin
         WR_VALID <= fq.pop_valid;
         {WR_BCAST, WR_OFFSET, WR_DATA} <= fq.pop_data;
      end
   end

   // ==========================================
   // Pins
   wire ret = tx_on ? sh_out[7] : n_sdi;
   wire alert_any = fault || n_alert;
   assign CRC_FAULT = fault;
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         {HOST_SERIAL_OUT, HOST_SERIAL_OUT_EN, SOUTH_SERIAL_OUT} <= 3'h0;
         {HOST_ALERT, SOUTH_ALERT, VERTICAL_STACK_BUS_IDLE} <= 3'h1;
         {NORTH_CS, NORTH_SCLK, NORTH_SERIAL_OUT} <= 3'h0;
      end
      else
      begin
         HOST_SERIAL_OUT <= base && cs_act && ret;
         HOST_SERIAL_OUT_EN <= base && cs_act;
         SOUTH_SERIAL_OUT <= !base && cs_act && ret;
         HOST_ALERT <= base && alert_any;
         SOUTH_ALERT <= !base && alert_any;
         VERTICAL_STACK_BUS_IDLE <= !cs_act;
         // no north select at address zero
         NORTH_CS <= cs_act && DEV_ADDR != `SSL_ADDR_ZERO;
         NORTH_SCLK <= cs_act && sck;
         NORTH_SERIAL_OUT <= cs_act && sdi;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_bad_end;
      wr_end && !wr_ok && crc_en;
   endsequence
   sequence s_crc_byte;
      rise && bit_cnt == 3'h0 && st == ST_RCRC;
   endsequence
   north_sel_a: assert property (NORTH_CS |-> $past(cs_act) && $past(DEV_ADDR) != 6'h00)
      else $error("north select while unaddressed or idle");
   vertical_stack_bus_idle_a: assert property (!cs_act [*2] |=> VERTICAL_STACK_BUS_IDLE && !NORTH_SCLK && !NORTH_CS)
      else $error("vertical lines active while deselected");
   clk_fwd_a: assert property (cs_act && sck |=> NORTH_SCLK)
      else $error("serial clock not forwarded");
   sdo_quiet_a: assert property (!cs_act |=> !SOUTH_SERIAL_OUT && !HOST_SERIAL_OUT)
      else $error("return data driven while deselected");
   crc_send_a: assert property (s_crc_byte |=> sh_out == $past(crc))
      else $error("checksum byte not loaded");
   data_fwd_a: assert property (cs_act |=> NORTH_SERIAL_OUT == $past(sdi))
      else $error("write data not relayed north");
   alert_out_a: assert property (fault [*2] |=> SOUTH_ALERT || HOST_ALERT)
      else $error("fault not signalled as alert");
   bcast_valid_a: assert property (fq.push_valid && pend_word.bcast |-> addr_valid)
      else $error("broadcast taken without valid address");
   bad_drop_a: assert property (s_bad_end |=> fault && !$rose(pend))
      else $error("bad packet not discarded");
   fault_end_a: assert property ($rose(fault) |-> $past(cs_end))
      else $error("fault set away from select release");
endmodule : ssl_link

// ---- tb/ssl_host_model.sv ----
// Purpose: Host controller model driving the host serial pins
// Assumes: Bench calls its tasks; CLK is the 4 ns block clock
// Notes: Serial clock stands low outside frames
`timescale 1ns/1ps
module ssl_host_model
(
   // Clock
   input wire logic clk,
   // Serial pins
   output logic cs_b,
   output logic sclk,
   output logic mosi,
   input wire logic miso
);
   // ==========================================
   // Link timing, 160 ns serial period
   localparam int HALF = 20;
   initial
   begin
      cs_b = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk
   // data held low around the frame
   task automatic select(input logic on);
      @(negedge clk);
      cs_b = ~on;
      mosi = 1'b0;
      wait_clk(HALF);
   endtask : select
   // ==========================================
   // Byte transfer
   // change on rise, sample on fall, MSB first
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge clk);
         sclk = 1'b1;
         mosi = tx[i];
         wait_clk(HALF);
         sclk = 1'b0;
         rx[i] = miso;
         wait_clk(HALF - 1);
      end
      mosi = 1'b0;
   endtask : xfer
endmodule : ssl_host_model

// ---- tb/ssl_link_tb_top.sv ----
// Purpose: Self-checking bench for the serial packet link
// Assumes: Base device except in s_relay; register file read data is offset xor 8'h5a
// Notes: Released host data pin floats high through its pull-up
`timescale 1ns/1ps
module ssl_link_tb_top
   import ssl_pkg::*;
;
   // ==========================================
   // Signals
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b, sclk, mosi, miso;
   logic base_sel = 1'b1;
   logic south_cs = 1'b0;
   logic south_sclk = 1'b0;
   logic south_in = 1'b0;
   logic north_in = 1'b0;
   logic north_alert = 1'b0;
   logic [5:0] dev_addr = 6'h05;
   logic csum_dis = 1'b0;
   logic fault_clear = 1'b0;
   logic wr_ready = 1'b0;
   logic [7:0] rd_data, rd_addr, wr_offset, wr_data;
   logic hso, hso_en, host_alert, south_out, south_alert;
   logic north_cs, north_sclk, north_out, vertical_stack_bus_idle, crc_fault, wr_valid, wr_bcast;
   logic [31:0] north_sr;
   logic [3:0] mon;
   logic [7:0] tx [16];
   logic [7:0] rx [16];
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   // ==========================================
   // Design, host and register file
   ssl_link dut (.CLK(clk), .RST_B(rst_b), .HOST_CS_B(cs_b), .HOST_SCLK(sclk),
      .HOST_SERIAL_IN(mosi), .HOST_SERIAL_OUT(hso), .HOST_SERIAL_OUT_EN(hso_en),
      .HOST_ALERT(host_alert), .SOUTH_CS(south_cs), .SOUTH_SCLK(south_sclk),
      .SOUTH_SERIAL_IN(south_in), .SOUTH_SERIAL_OUT(south_out), .SOUTH_ALERT(south_alert),
      .NORTH_SERIAL_IN(north_in), .NORTH_ALERT(north_alert), .NORTH_CS(north_cs),
      .NORTH_SCLK(north_sclk), .NORTH_SERIAL_OUT(north_out), .BASE_SEL(base_sel),
      .DEV_ADDR(dev_addr), .CHECKSUM_DISABLE(csum_dis), .FAULT_CLEAR(fault_clear),
      .VERTICAL_STACK_BUS_IDLE(vertical_stack_bus_idle), .CRC_FAULT(crc_fault), .RD_DATA(rd_data), .RD_ADDR(rd_addr),
      .WR_READY(wr_ready), .WR_VALID(wr_valid), .WR_BCAST(wr_bcast),
      .WR_OFFSET(wr_offset), .WR_DATA(wr_data));
   ssl_host_model host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .mosi(mosi), .miso(miso));
   assign miso = hso_en ? hso : 1'b1;
   assign rd_data = rd_addr ^ 8'h5a;
   always #2 clk = ~clk;
   // Vertical lines seen where the host samples
   always @(negedge sclk)
   begin
      north_sr <= {north_sr[30:0], north_out};
      mon <= {north_cs, vertical_stack_bus_idle, north_sclk, hso};
   end
   // Hang guard, far above the expected run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // poly 07, zero start, MSB first
   function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      repeat (8) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
      return r;
   endfunction : crc_add
   task automatic pkt(input int n);
      host.select(1'b1);
      for (int i = 0; i < n; i++)
         host.xfer(tx[i], rx[i]);
      host.select(1'b0);
   endtask : pkt
   task automatic wr(input logic [5:0] a, input logic [7:0] off, input logic [7:0] d,
                     input logic good, input logic with_crc);
      tx[0] = {1'b0, a, 1'b1};
      tx[1] = off;
      tx[2] = d;
      tx[3] = crc_add(crc_add(crc_add(8'h00, tx[0]), off), d) ^ {7'h00, ~good};
      pkt(with_crc ? 4 : 3);
   endtask : wr
   task automatic take_wr(output logic got);
      int k;
      k = 0;
      while (wr_valid !== 1'b1 && k < 40)
      begin
         @(negedge clk);
         k++;
      end
      got = wr_valid;
   endtask : take_wr
   task automatic accept;
      wr_ready = 1'b1;
      @(negedge clk);
      wr_ready = 1'b0;
   endtask : accept
   task automatic expect_wr(input logic bc, input logic [7:0] off, input logic [7:0] d);
      logic got;
      take_wr(got);
      check("wr_valid", got, 1'b1);
      check("wr_bcast", wr_bcast, bc);
      check("wr_offset", wr_offset, off);
      check("wr_data", wr_data, d);
      accept();
   endtask : expect_wr
   task automatic no_wr;
      logic got;
      take_wr(got);
      check("no_write", got, 1'b0);
   endtask : no_wr
   // ==========================================
   // Scenarios
   task automatic s_reset;
      check("vertical_stack_bus_idle", vertical_stack_bus_idle, 1'b1);
      check("north_cs", north_cs, 1'b0);
      check("north_out", north_out, 1'b0);
      check("south_out", south_out, 1'b0);
      check("crc_fault", crc_fault, 1'b0);
   endtask : s_reset
   task automatic s_write;
      wr(6'h05, 8'h12, 8'ha7, 1'b1, 1'b1);
      check("north_bits", north_sr, {tx[0], tx[1], tx[2], tx[3]});
      check("vertical_stack_bus_lines", mon, 4'b1010);
      check("vertical_stack_bus_idle", vertical_stack_bus_idle, 1'b1);
      expect_wr(1'b0, 8'h12, 8'ha7);
      wr(6'h3f, 8'h20, 8'h01, 1'b1, 1'b1);
      expect_wr(1'b1, 8'h20, 8'h01);
   endtask : s_write
   task automatic s_bad;
      for (int i = 0; i < 2; i++)
      begin
         wr(6'h05, 8'h13, 8'h55, i[0], i == 0);
         no_wr();
         check("crc_fault", crc_fault, 1'b1);
         check("host_alert", host_alert, 1'b1);
         check("south_alert", south_alert, 1'b0);
         // fault cleared before the next write
         @(negedge clk);
         fault_clear = 1'b1;
         @(negedge clk);
         fault_clear = 1'b0;
         repeat (3) @(negedge clk);
         check("fault_cleared", {crc_fault, host_alert}, 2'h0);
      end
   endtask : s_bad
   task automatic s_nocrc;
      csum_dis = 1'b1;
      wr(6'h05, 8'h31, 8'h44, 1'b1, 1'b0);
      expect_wr(1'b0, 8'h31, 8'h44);
      wr(6'h05, 8'h31, 8'h44, 1'b1, 1'b1);
      no_wr();
      check("crc_fault", crc_fault, 1'b0);
      csum_dis = 1'b0;
      wr(6'h09, 8'h31, 8'h44, 1'b0, 1'b1);
      no_wr();
      check("crc_fault", crc_fault, 1'b0);
   endtask : s_nocrc
   task automatic s_read;
      logic [7:0] c;
      logic [7:0] v;
      tx[0] = 8'h0a;
      tx[1] = 8'h40;
      tx[2] = 8'h0c;
      for (int i = 3; i < 16; i++)
         tx[i] = 8'hff;
      pkt(16);
      c = crc_add(crc_add(crc_add(8'h00, 8'h0a), 8'h40), 8'h0c);
      for (int i = 0; i < 12; i++)
      begin
         v = (8'h40 + i[7:0]) ^ 8'h5a;
         check("read_byte", rx[i + 3], v);
         c = crc_add(c, v);
      end
      check("read_crc", rx[15], c);
      check("rd_addr", rd_addr, 8'h4c);
      check("host_out_en", hso_en, 1'b0);
   endtask : s_read
   task automatic s_addr0;
      dev_addr = 6'h00;
      wr(6'h09, 8'h01, 8'h02, 1'b1, 1'b1);
      check("north_cs", mon[3], 1'b0);
      wr(6'h3f, 8'h01, 8'h02, 1'b1, 1'b1);
      no_wr();
      dev_addr = 6'h05;
   endtask : s_addr0
   task automatic s_alert;
      north_alert = 1'b1;
      repeat (8) @(negedge clk);
      check("alert_relay", host_alert, 1'b1);
      north_alert = 1'b0;
      repeat (8) @(negedge clk);
      check("alert_relay", host_alert, 1'b0);
   endtask : s_alert
   // Non-base device: relay toward the south side
   task automatic s_relay;
      base_sel = 1'b0;
      south_cs = 1'b1;
      north_in = 1'b1;
      north_alert = 1'b1;
      repeat (8) @(negedge clk);
      check("relay_data", {south_out, hso_en, north_cs}, 3'b101);
      check("relay_alert", {south_alert, host_alert}, 2'b10);
      south_cs = 1'b0;
      north_in = 1'b0;
      north_alert = 1'b0;
      base_sel = 1'b1;
      repeat (8) @(negedge clk);
      check("relay_idle", {south_out, south_alert}, 2'b00);
   endtask : s_relay
   task automatic s_fifo;
      logic got;
      int n;
      csum_dis = 1'b1;
      for (int i = 0; i < 11; i++)
         wr(6'h05, 8'h60, 8'hc0 + i[7:0], 1'b1, 1'b0);
      n = 0;
      take_wr(got);
      while (got === 1'b1 && n < 12)
      begin
         check("fifo_order", wr_data, 8'hc0 + n[7:0]);
         accept();
         n++;
         take_wr(got);
      end
      check("fifo_full", n >= 8 && n < 11, 1'b1);
      csum_dis = 1'b0;
   endtask : s_fifo
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      s_reset();
      s_write();
      s_bad();
      s_nocrc();
      s_read();
      s_addr0();
      s_alert();
      s_relay();
      s_fifo();
      wrap_up();
   end
endmodule : ssl_link_tb_top
